// ### core/ppmc_capability.v
// power-management capability structure: header and control/status
// assumes configuration accesses arrive as one-cycle strobes on clock
`timescale 1ns/1ps
`include "ppmc_consts.vh"

// Function
// - header top five bits report wake from D0, D1, D2 and D3
// - header bits 26 and 25 report D2 and D1 support as ones
// - header bits 24:22 report auxiliary current for cold wake
// - device-specific-initialization bit reads zero
// - read-only bit tells whether wake needs the bus clock
// - version field reads binary 010
// - next-item pointer byte always reads zero
// - capability identifier byte always reads 01 hex
// - wake status sets on any wake event, whatever the enable
// - writing one clears wake status; writing zero leaves it
// - data-scale field is read-only and carries no scaling
// - data-select field stores writes but selects nothing
// - wake enable one permits the wake signal, zero blocks it
// - both command bits 18 and 19 set enable magic-packet wake by default
// - power-state field reads and writes, 00 D0 to 11 D3hot
// - power-state field returns to D0 when power is restored
module ppmc_capability (
	// clock and reset
	input wire clock,
	input wire rst,
	// configuration access port
	input wire [7:0] cfgAddr,
	input wire cfgRead,
	input wire cfgWrite,
	input wire [3:0] cfgByteEn,
	input wire [31:0] cfgWrData,
	output reg [31:0] cfgRdData_q,
	output reg cfgRdValid_q,
	output reg cfgWrDone_q,
	// device side events and controls
	input wire wakeEvent,
	input wire powerResume,
	input wire [1:0] cmdMagicBits,
	// wake pin, open drain, active low
	output wire wakePinOut,
	output reg wakePinOe_q,
	// state seen by the rest of the device
	output reg wakeActive_q,
	output reg magicWakeDefault_q,
	output reg [1:0] powerState_q,
	output reg [3:0] powerStateIs_q,
	output reg powerStateChg_q,
	output reg [3:0] dataSelect_q,
	output reg wakeEnable_q,
	output wire wakeStatus
);

	// address decode of the two dwords
	wire hitHdr;
	wire hitCsr;
	wire [3:0] laneWr;
	wire statusClear;
	wire [31:0] hdrValue;
	wire [31:0] csrValue;
	wire [1:0] newPowerState;
	reg [31:0] rdMux;

	// the structure occupies two aligned dwords; low address bits are
	// ignored because accesses are always dword wide with byte enables
	assign hitHdr = ({cfgAddr[7:2], 2'b00} == `PPMC_HDR_OFFSET);
	assign hitCsr = ({cfgAddr[7:2], 2'b00} == `PPMC_CSR_OFFSET);

	// per-lane write strobes for the control/status dword
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane = lane + 1) begin : gLaneWr
			assign laneWr[lane] = cfgWrite & hitCsr & cfgByteEn[lane];
		end
	endgenerate

	// capability header is hard-wired; writes to it are dropped
	assign hdrValue[`PPMC_WSUP_HI:`PPMC_WSUP_LO] =
		`PPMC_WSUP_VAL;
	assign hdrValue[`PPMC_ST2_BIT] = `PPMC_STSUP_VAL;
	assign hdrValue[`PPMC_ST1_BIT] = `PPMC_STSUP_VAL;
	assign hdrValue[`PPMC_AUX_HI:`PPMC_AUX_LO] =
		`PPMC_AUX_VAL;
	assign hdrValue[`PPMC_DSI_BIT] = `PPMC_DSI_VAL;
	assign hdrValue[`PPMC_HRES_BIT] = 1'b0; // reserved
	assign hdrValue[`PPMC_CLK_BIT] = `PPMC_CLK_VAL;
	assign hdrValue[`PPMC_VER_HI:`PPMC_VER_LO] =
		`PPMC_VER_VAL;
	assign hdrValue[`PPMC_NIP_HI:`PPMC_NIP_LO] =
		`PPMC_NIP_VAL;
	assign hdrValue[`PPMC_CAPABILITY_IDENTIFIER_HI:`PPMC_CAPABILITY_IDENTIFIER_LO] =
		`PPMC_CAPABILITY_IDENTIFIER_VAL;

	// write-one-to-clear of the wake status, only through its lane
	assign statusClear = laneWr[`PPMC_LANE_WAKE] &
		cfgWrData[`PPMC_WSTAT_BIT];

	// sticky wake status, fed by every wake event regardless of enable
	ppmc_wake_flag uWakeFlag (
		.clock(clock),
		.rst(rst),
		.setPulse(wakeEvent),
		.clearPulse(statusClear),
		.flagQ(wakeStatus)
	);

	// control/status dword as software reads it
	assign csrValue[31:16] = 16'h0000; // reserved
	assign csrValue[`PPMC_WSTAT_BIT] = wakeStatus;
	assign csrValue[`PPMC_SCALE_HI:`PPMC_SCALE_LO] =
		`PPMC_SCALE_VAL;
	assign csrValue[`PPMC_DATA_SELECT_FIELD_HI:`PPMC_DATA_SELECT_FIELD_LO] = dataSelect_q;
	assign csrValue[`PPMC_WEN_BIT] = wakeEnable_q;
	assign csrValue[7:2] = 6'h00; // reserved
	assign csrValue[`PPMC_PWR_HI:`PPMC_PWR_LO] = powerState_q;

	// power state requested by a write on the low lane
	assign newPowerState = cfgWrData[`PPMC_PWR_HI:`PPMC_PWR_LO];

	// data select is plain storage; nothing downstream reads it
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			dataSelect_q <= 4'h0;
		end else if (laneWr[`PPMC_LANE_WAKE]) begin
			dataSelect_q <=
				cfgWrData[`PPMC_DATA_SELECT_FIELD_HI:`PPMC_DATA_SELECT_FIELD_LO];
		end
	end

	// wake enable bit, written through the upper control lane
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			wakeEnable_q <= 1'b0;
		end else if (laneWr[`PPMC_LANE_WAKE]) begin
			wakeEnable_q <= cfgWrData[`PPMC_WEN_BIT];
		end
	end

	// power-state field; a power resume outranks a software write so
	// the device always comes back in D0 after power returns
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			powerState_q <= `PPMC_D0;
		end else if (powerResume) begin
			powerState_q <= `PPMC_D0;
		end else if (laneWr[`PPMC_LANE_PWR]) begin
			powerState_q <= newPowerState;
		end
	end

	// one-cycle pulse whenever the stored power state moves
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			powerStateChg_q <= 1'b0;
		end else if (powerResume) begin
			powerStateChg_q <= (powerState_q != `PPMC_D0);
		end else if (laneWr[`PPMC_LANE_PWR]) begin
			powerStateChg_q <= (powerState_q != newPowerState);
		end else begin
			powerStateChg_q <= 1'b0;
		end
	end

	// one-hot view of the power state, one flop per encoding
	genvar st;
	generate
		for (st = 0; st < 4; st = st + 1) begin : gStateIs
			always @(posedge clock or posedge rst) begin
				if (rst) begin
					powerStateIs_q[st] <= (st == 0);
				end else if (powerResume) begin
					powerStateIs_q[st] <= (st == 0);
				end else if (laneWr[`PPMC_LANE_PWR]) begin
					powerStateIs_q[st] <=
						({30'h0, newPowerState} == st);
				end
			end
		end
	endgenerate

	// wake is driven only while status is pending and enabled; a
	// clear of the status drops the pin one cycle after the write
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			wakeActive_q <= 1'b0;
			wakePinOe_q <= 1'b0;
		end else begin
			wakeActive_q <= wakeStatus & wakeEnable_q;
			wakePinOe_q <= wakeStatus & wakeEnable_q;
		end
	end

	// open drain: the pin is only ever pulled low, never driven high
	assign wakePinOut = 1'b0;

	// magic-packet wake is enabled by default whenever both command
	// bits are set, independent of the wake enable bit
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			magicWakeDefault_q <= 1'b0;
		end else begin
			magicWakeDefault_q <= &cmdMagicBits;
		end
	end

	// read multiplexer; unmapped dwords read as zero
	always @* begin
		rdMux = 32'h00000000;
		if (hitHdr) begin
			rdMux = hdrValue;
		end else if (hitCsr) begin
			rdMux = csrValue;
		end
	end

	// read data is captured in the cycle after the strobe
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			cfgRdData_q <= 32'h00000000;
			cfgRdValid_q <= 1'b0;
		end else begin
			cfgRdValid_q <= cfgRead;
			if (cfgRead) begin
				cfgRdData_q <= rdMux;
			end
		end
	end

	// write completion pulse, also given for unmapped addresses
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			cfgWrDone_q <= 1'b0;
		end else begin
			cfgWrDone_q <= cfgWrite;
		end
	end

endmodule // ppmc_capability

// ### core/ppmc_consts.vh
// constants for the power-management capability structure
// assumes byte addresses in configuration space and 32-bit dwords
`ifndef PPMC_CONSTS_VH
`define PPMC_CONSTS_VH

// register byte offsets in configuration space
`define PPMC_HDR_OFFSET 8'hC0
`define PPMC_CSR_OFFSET 8'hC4

// reset values of both dwords
`define PPMC_HDR_RESET 32'hFE820001
`define PPMC_CSR_RESET 32'h00000000

// capability header fields and their fixed values
`define PPMC_WSUP_HI 31
`define PPMC_WSUP_LO 27
`define PPMC_WSUP_VAL 5'h1F
`define PPMC_ST2_BIT 26
`define PPMC_ST1_BIT 25
`define PPMC_STSUP_VAL 1'h1
`define PPMC_AUX_HI 24
`define PPMC_AUX_LO 22
`define PPMC_AUX_VAL 3'h2
`define PPMC_DSI_BIT 21
`define PPMC_DSI_VAL 1'h0
`define PPMC_HRES_BIT 20
`define PPMC_CLK_BIT 19
`define PPMC_CLK_VAL 1'h0
`define PPMC_VER_HI 18
`define PPMC_VER_LO 16
`define PPMC_VER_VAL 3'h2
`define PPMC_NIP_HI 15
`define PPMC_NIP_LO 8
`define PPMC_NIP_VAL 8'h00
`define PPMC_CAPABILITY_IDENTIFIER_HI 7
`define PPMC_CAPABILITY_IDENTIFIER_LO 0
`define PPMC_CAPABILITY_IDENTIFIER_VAL 8'h01

// control/status fields
`define PPMC_WSTAT_BIT 15
`define PPMC_SCALE_HI 14
`define PPMC_SCALE_LO 13
`define PPMC_SCALE_VAL 2'h0
`define PPMC_DATA_SELECT_FIELD_HI 12
`define PPMC_DATA_SELECT_FIELD_LO 9
`define PPMC_WEN_BIT 8
`define PPMC_PWR_HI 1
`define PPMC_PWR_LO 0

// power-state encodings
`define PPMC_D0 2'h0
`define PPMC_D1 2'h1
`define PPMC_D2 2'h2
`define PPMC_D3HOT 2'h3

// byte lanes of the control/status dword that hold writable fields
`define PPMC_LANE_PWR 0
`define PPMC_LANE_WAKE 1

// timing counts in clock cycles
`define PPMC_RD_LATENCY 1
`define PPMC_WR_LATENCY 1

`endif

// ### core/ppmc_wake_flag.v
// sticky wake-event flag with write-one-to-clear
// assumes setPulse and clearPulse are synchronous one-cycle pulses
`timescale 1ns/1ps

module ppmc_wake_flag (
	// clock and reset
	input wire clock,
	input wire rst,
	// event and clear
	input wire setPulse,
	input wire clearPulse,
	// flag state
	output reg flagQ
);

	// a set in the clearing cycle wins so no event is lost
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			flagQ <= 1'b0;
		end else if (setPulse) begin
			flagQ <= 1'b1;
		end else if (clearPulse) begin
			flagQ <= 1'b0;
		end
	end

endmodule // ppmc_wake_flag

// ### test/ppmc_capability_chk.sv
// checker for the power-management capability block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps

module ppmc_capability_chk (
	// clock and reset
	input wire clock,
	input wire rst,
	// access port
	input wire [7:0] cfgAddr,
	input wire cfgRead,
	input wire cfgWrite,
	input wire [3:0] cfgByteEn,
	input wire [31:0] cfgWrData,
	input wire [31:0] cfgRdData_q,
	input wire cfgRdValid_q,
	// events and state
	input wire wakeEvent,
	input wire powerResume,
	input wire [1:0] cmdMagicBits,
	input wire wakePinOe_q,
	input wire wakeActive_q,
	input wire magicWakeDefault_q,
	input wire [1:0] powerState_q,
	input wire wakeEnable_q,
	input wire wakeStatus
);
	// software write-one clear of the wake status
	wire csrWr = cfgWrite && cfgAddr[7:2] == 6'h31;
	wire stClr = csrWr && cfgByteEn[1] && cfgWrData[15];
	default clocking dc @(posedge clock); endclocking
	default disable iff (rst);
hdr_upper_a:
	assert property (cfgRead && cfgAddr[7:2] == 6'h30 |=> cfgRdValid_q
		&& cfgRdData_q[31:16] == 16'hFE82) else $error("header high wrong");
hdr_lower_a:
	assert property (cfgRead && cfgAddr[7:2] == 6'h30 |=> cfgRdValid_q
		&& cfgRdData_q[15:0] == 16'h0001) else $error("header low wrong");
stat_set_a:
	assert property (wakeEvent |=> wakeStatus) else $error("status not set");
stat_clr_a:
	assert property (stClr && !wakeEvent |=> !wakeStatus)
		else $error("status not cleared");
stat_keep_a:
	assert property (!wakeEvent && !stClr |=> $stable(wakeStatus))
		else $error("status changed");
pin_follow_a:
	assert property (!$past(rst) |-> wakePinOe_q ==
		$past(wakeStatus && wakeEnable_q)) else $error("wake pin wrong");
act_follow_a:
	assert property (!$past(rst) |-> wakeActive_q ==
		$past(wakeStatus && wakeEnable_q)) else $error("wake active wrong");
magic_dflt_a:
	assert property (!$past(rst) |-> magicWakeDefault_q ==
		$past(&cmdMagicBits)) else $error("magic default wrong");
pwr_write_a:
	assert property (csrWr && cfgByteEn[0] && !powerResume |=>
		powerState_q == $past(cfgWrData[1:0])) else $error("state write");
resume_d0_a:
	assert property (powerResume |=> powerState_q == 2'h0)
		else $error("state not D0");
endmodule // ppmc_capability_chk

bind ppmc_capability ppmc_capability_chk chk_u (
	.clock(clock), .rst(rst), .cfgAddr(cfgAddr), .cfgRead(cfgRead),
	.cfgWrite(cfgWrite), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
	.cfgRdData_q(cfgRdData_q), .cfgRdValid_q(cfgRdValid_q),
	.wakeEvent(wakeEvent), .powerResume(powerResume),
	.cmdMagicBits(cmdMagicBits), .wakePinOe_q(wakePinOe_q),
	.wakeActive_q(wakeActive_q),
	.magicWakeDefault_q(magicWakeDefault_q),
	.powerState_q(powerState_q), .wakeEnable_q(wakeEnable_q),
	.wakeStatus(wakeStatus)
);

// ### test/ppmc_host_model.sv
// host-side model: issues configuration reads and writes
// assumes the block answers on the taking edge, one cycle after the request
`timescale 1ns/1ps

module ppmc_host_model (
	// clock
	input wire clock,
	// requests toward the block
	output reg [7:0] cfgAddr,
	output reg cfgRead,
	output reg cfgWrite,
	output reg [3:0] cfgByteEn,
	output reg [31:0] cfgWrData,
	// answers
	input wire [31:0] cfgRdData_q,
	input wire cfgRdValid_q,
	input wire cfgWrDone_q
);
	// idle bus at time zero
	initial begin
		{cfgAddr, cfgRead, cfgWrite, cfgByteEn, cfgWrData} = 46'h0;
	end
	// one access; strobes drop to zero, the other lines carry the inverse of the last value
	task acc(input w, input [7:0] a, input [3:0] be, input [31:0] wd,
		output [31:0] d, output v);
		begin
			@(posedge clock);
			{cfgRead, cfgWrite} <= {!w, w};
			{cfgAddr, cfgByteEn, cfgWrData} <= {a, be, wd};
			@(posedge clock);
			{cfgRead, cfgWrite} <= 2'h0;
			{cfgAddr, cfgByteEn, cfgWrData} <= ~{a, be, wd};
			#1;
			d = cfgRdData_q;
			v = w ? cfgWrDone_q : cfgRdValid_q;
		end
	endtask
endmodule // ppmc_host_model

// ### test/ppmc_capability_tb.sv
// self-checking bench for the power-management capability block
// assumes the host model drives the access port
`timescale 1ns/1ps

module ppmc_capability_tb;
	reg clock, rst, wakeEvent, powerResume, v;
	reg [1:0] cmdMagicBits;
	reg [31:0] d;
	integer nFail, checkCount, s;
	wire [7:0] cfgAddr;
	wire cfgRead, cfgWrite, cfgRdValid_q, cfgWrDone_q, wakePinOut;
	wire wakePinOe_q, wakeActive_q, magicWakeDefault_q, powerStateChg_q;
	wire wakeEnable_q, wakeStatus;
	wire [3:0] cfgByteEn, powerStateIs_q, dataSelect_q;
	wire [31:0] cfgWrData, cfgRdData_q;
	wire [1:0] powerState_q;
	ppmc_capability dut_u (
		.clock(clock), .rst(rst), .cfgAddr(cfgAddr), .cfgRead(cfgRead),
		.cfgWrite(cfgWrite), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
		.cfgRdData_q(cfgRdData_q), .cfgRdValid_q(cfgRdValid_q),
		.cfgWrDone_q(cfgWrDone_q), .wakeEvent(wakeEvent),
		.powerResume(powerResume), .cmdMagicBits(cmdMagicBits),
		.wakePinOut(wakePinOut), .wakePinOe_q(wakePinOe_q),
		.wakeActive_q(wakeActive_q),
		.magicWakeDefault_q(magicWakeDefault_q),
		.powerState_q(powerState_q), .powerStateIs_q(powerStateIs_q),
		.powerStateChg_q(powerStateChg_q), .dataSelect_q(dataSelect_q),
		.wakeEnable_q(wakeEnable_q), .wakeStatus(wakeStatus)
	);
	ppmc_host_model host_u (
		.clock(clock), .cfgAddr(cfgAddr), .cfgRead(cfgRead),
		.cfgWrite(cfgWrite), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
		.cfgRdData_q(cfgRdData_q), .cfgRdValid_q(cfgRdValid_q),
		.cfgWrDone_q(cfgWrDone_q)
	);
	// clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// word compare and flag compare
	task cmp(input [95:0] n, input [31:0] e, input [31:0] g);
		begin
			checkCount = checkCount + 1;
			if (g !== e) begin
				nFail = nFail + 1;
				$display("MISMATCH %0s exp %h got %h", n, e, g);
			end
		end
	endtask
	task cmp1(input [95:0] n, input e, input g);
		cmp(n, {31'h0, e}, {31'h0, g});
	endtask
	// bus helpers
	task rdc(input [7:0] a, input [31:0] e, input [95:0] n);
		begin
			host_u.acc(1'b0, a, 4'h0, 32'h0, d, v);
			cmp1("rvalid", 1'b1, v);
			cmp(n, e, d);
		end
	endtask
	task wr(input [7:0] a, input [3:0] be, input [31:0] wd);
		begin
			host_u.acc(1'b1, a, be, wd, d, v);
			cmp1("wdone", 1'b1, v);
		end
	endtask
	task pulseWake;
		begin
			@(posedge clock);
			wakeEvent <= 1'b1;
			@(posedge clock);
			wakeEvent <= 1'b0;
			#1;
		end
	endtask
	// header, read-only and unmapped accesses
	task testHeader;
		begin
			rdc(8'hC0, 32'hFE820001, "hdr");
			cmp1("init bit", 1'b0, d[21]);
			cmp1("clock bit", 1'b0, d[19]);
			cmp("version", 32'h2, {29'h0, d[18:16]});
			cmp("next ptr", 32'h0, {24'h0, d[15:8]});
			cmp("cap id", 32'h1, {24'h0, d[7:0]});
			wr(8'hC0, 4'hF, 32'h0);
			rdc(8'hC0, 32'hFE820001, "hdr ro");
			rdc(8'h80, 32'h0, "unmapped");
		end
	endtask
	// every power state, then power resume
	task testState;
		begin
			for (s = 0; s < 4; s = s + 1) begin
				wr(8'hC4, 4'h1, s);
				cmp1("changed", s != 0, powerStateChg_q);
				rdc(8'hC4, s, "state");
				cmp("onehot", 32'h1 << s, {28'h0, powerStateIs_q});
			end
			@(posedge clock);
			powerResume <= 1'b1;
			@(posedge clock);
			powerResume <= 1'b0;
			#1;
			cmp("resume", 32'h0, {30'h0, powerState_q});
			cmp("resume hot", 32'h1, {28'h0, powerStateIs_q});
			cmp1("resume chg", 1'b1, powerStateChg_q);
		end
	endtask
	// wake status, enable and pin
	task testWake;
		begin
			wr(8'hC4, 4'h2, 32'h0100);
			pulseWake;
			cmp1("status", 1'b1, wakeStatus);
			@(posedge clock);
			#1;
			cmp1("pin", 1'b1, wakePinOe_q);
			cmp1("active", 1'b1, wakeActive_q);
			cmp1("pin level", 1'b0, wakePinOut);
			wr(8'hC4, 4'h2, 32'h0100);
			cmp1("keep", 1'b1, wakeStatus);
			wr(8'hC4, 4'h2, 32'h8000);
			cmp1("clear", 1'b0, wakeStatus);
			pulseWake;
			@(posedge clock);
			#1;
			cmp1("blocked", 1'b0, wakePinOe_q);
			cmp1("inactive", 1'b0, wakeActive_q);
			wr(8'hC4, 4'hE, 32'hFFFF7E00);
			rdc(8'hC4, 32'h00009E00, "select");
			cmp("data_select_field", 32'hF, {28'h0, dataSelect_q});
		end
	endtask
	// magic-packet default enable
	task testMagic;
		begin
			@(posedge clock);
			cmdMagicBits <= 2'h3;
			repeat (2) @(posedge clock);
			#1;
			cmp1("magic", 1'b1, magicWakeDefault_q);
			@(posedge clock);
			cmdMagicBits <= 2'h1;
			repeat (2) @(posedge clock);
			#1;
			cmp1("nomagic", 1'b0, magicWakeDefault_q);
		end
	endtask
	task endSim;
		begin
			if (nFail == 0 && checkCount > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// watchdog
	initial begin
		#20000;
		nFail = nFail + 1;
		endSim;
	end
	// main sequence
	initial begin
		{nFail, checkCount} = 64'h0;
		{rst, wakeEvent, powerResume, cmdMagicBits} = 5'h10;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		rdc(8'hC4, 32'h0, "csr reset");
		testHeader;
		testState;
		testWake;
		testMagic;
		endSim;
	end
endmodule // ppmc_capability_tb
